// file: inc/cpuc_consts.vh
`ifndef CPUC_CONSTS_VH
`define CPUC_CONSTS_VH
// ----------------------------------------
// timing
// ----------------------------------------
`define CPUC_CLK_NS 50
`define CPUC_TCY_NS 200
`define CPUC_TCY_CYC ((`CPUC_TCY_NS + `CPUC_CLK_NS - 1) / `CPUC_CLK_NS)
// ----------------------------------------
// reset values
// ----------------------------------------
`define CPUC_RESET_VEC 9'h1ff
`define CPUC_NOP 12'h000
`define CPUC_STATUS_RST 8'h18
`define CPUC_FSR_RST 8'h00
`define CPUC_W_RST 8'h00
// ----------------------------------------
// data space map
// ----------------------------------------
`define CPUC_A_INDF 5'h00
`define CPUC_A_PCL 5'h02
`define CPUC_A_STATUS 5'h03
`define CPUC_A_FSR 5'h04
`define CPUC_RAM_LO 7
`define CPUC_RAM_HI 31
// ----------------------------------------
// status bit positions
// ----------------------------------------
`define CPUC_BIT_C 0
`define CPUC_BIT_DC 1
`define CPUC_BIT_Z 2
`endif

// file: rtl/cpuc_core.v
`timescale 1ns/1ns
`include "cpuc_consts.vh"

module cpuc_core #(
  parameter STACK_DEPTH = 4,
  parameter PC_W = 9
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  input wire clockEn,
  // program memory
  output wire [PC_W-1:0] progAddr,
  input wire [11:0] progData,
  // data register file, external part
  output wire [4:0] dataRdAddr,
  input wire [7:0] dataRdData,
  output wire [4:0] dataWrAddr,
  output wire [7:0] dataWrData,
  output wire dataWe
);

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  reg rstMeta_q, rstSync_q;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // ----------------------------------------
  // instruction cycle phases
  // ----------------------------------------
  localparam integer TCY = `CPUC_TCY_CYC;
  localparam [1:0] PH_LAST = TCY[1:0] - 2'h1;
  reg [1:0] phase_q;
  wire step = clockEn & (phase_q == PH_LAST);
  always @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      phase_q <= 2'h0;
    end else if (clockEn) begin
      phase_q <= (phase_q == PH_LAST) ? 2'h0 : phase_q + 2'h1;
    end
  end

  // ----------------------------------------
  // architectural state
  // ----------------------------------------
  reg [PC_W-1:0] pc_q;
  reg [11:0] instr_q;
  reg [7:0] w_q;
  reg [7:0] status_q;
  reg [7:0] fsr_q;
  reg [PC_W-1:0] stk_q [0:STACK_DEPTH-1];
  reg [7:0] ram [`CPUC_RAM_LO:`CPUC_RAM_HI];
  reg [4:0] dataRdAddr_q;
  reg [4:0] dataWrAddr_q;
  reg [7:0] dataWrData_q;
  reg dataWe_q;
  integer i;

  // ----------------------------------------
  // operand selection
  // ----------------------------------------
  wire [4:0] fField = instr_q[4:0];
  wire [4:0] fa = (fField == `CPUC_A_INDF) ? fsr_q[4:0] : fField;
  wire dBit = instr_q[5];
  wire [2:0] bitSel = instr_q[7:5];
  wire [7:0] lit = instr_q[7:0];
  wire faCore = (fa == `CPUC_A_INDF) | (fa == `CPUC_A_PCL) | (fa == `CPUC_A_STATUS) | (fa == `CPUC_A_FSR);
  wire faRam = (fa >= `CPUC_RAM_LO);
  wire faExt = ~faCore & ~faRam;
  reg [7:0] fVal;
  always @* begin
    case (fa)
      `CPUC_A_INDF: fVal = 8'h00;
      `CPUC_A_PCL: fVal = pc_q[7:0];
      `CPUC_A_STATUS: fVal = status_q;
      `CPUC_A_FSR: fVal = fsr_q;
      default: fVal = faRam ? ram[fa] : dataRdData;
    endcase
  end

  // ----------------------------------------
  // decode and arithmetic
  // ----------------------------------------
  reg [7:0] res;
  reg [8:0] sum;
  reg [4:0] nib;
  reg useD, wrW, wrF, updZ, updC, updDC;
  reg cNew, dcNew, skip, jump, push, pop;
  reg [PC_W-1:0] target;
  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    res = 8'h00;
    useD = 1'b0;
    wrW = 1'b0;
    wrF = 1'b0;
    updZ = 1'b0;
    updC = 1'b0;
    updDC = 1'b0;
    cNew = status_q[`CPUC_BIT_C];
    dcNew = status_q[`CPUC_BIT_DC];
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    target = pc_q;
    casez (instr_q[11:6])
      6'b000000: begin
        // control forms without d are treated as no-ops here
        res = w_q;
        wrF = dBit;
      end
      6'b000001: begin
        res = 8'h00;
        updZ = 1'b1;
        wrF = dBit;
        wrW = ~dBit;
      end
      6'b000010: begin
        // f + ~w + 1, carry out high means no borrow
        sum = {1'b0, fVal} + {1'b0, ~w_q} + 9'h001;
        nib = {1'b0, fVal[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;
        res = sum[7:0];
        cNew = sum[8];
        dcNew = nib[4];
        updC = 1'b1;
        updDC = 1'b1;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b000011: begin
        res = fVal - 8'h01;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b000100: begin
        res = w_q | fVal;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b000101: begin
        res = w_q & fVal;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b000110: begin
        res = w_q ^ fVal;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b000111: begin
        sum = {1'b0, w_q} + {1'b0, fVal};
        nib = {1'b0, w_q[3:0]} + {1'b0, fVal[3:0]};
        res = sum[7:0];
        cNew = sum[8];
        dcNew = nib[4];
        updC = 1'b1;
        updDC = 1'b1;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b001000: begin
        res = fVal;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b001001: begin
        res = ~fVal;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b001010: begin
        res = fVal + 8'h01;
        updZ = 1'b1;
        useD = 1'b1;
      end
      6'b001011: begin
        res = fVal - 8'h01;
        skip = (res == 8'h00);
        useD = 1'b1;
      end
      6'b001100: begin
        res = {status_q[`CPUC_BIT_C], fVal[7:1]};
        cNew = fVal[0];
        updC = 1'b1;
        useD = 1'b1;
      end
      6'b001101: begin
        res = {fVal[6:0], status_q[`CPUC_BIT_C]};
        cNew = fVal[7];
        updC = 1'b1;
        useD = 1'b1;
      end
      6'b001110: begin
        res = {fVal[3:0], fVal[7:4]};
        useD = 1'b1;
      end
      6'b001111: begin
        res = fVal + 8'h01;
        skip = (res == 8'h00);
        useD = 1'b1;
      end
      6'b0100??: begin
        res = fVal & ~(8'h01 << bitSel);
        wrF = 1'b1;
      end
      6'b0101??: begin
        res = fVal | (8'h01 << bitSel);
        wrF = 1'b1;
      end
      6'b0110??: skip = ~fVal[bitSel];
      6'b0111??: skip = fVal[bitSel];
      6'b1000??: begin
        res = lit;
        wrW = 1'b1;
        pop = 1'b1;
        jump = 1'b1;
        target = stk_q[0];
      end
      6'b1001??: begin
        push = 1'b1;
        jump = 1'b1;
        target = {{(PC_W-8){1'b0}}, lit};
      end
      6'b101???: begin
        jump = 1'b1;
        target = instr_q[PC_W-1:0];
      end
      6'b1100??: begin
        res = lit;
        wrW = 1'b1;
      end
      6'b1101??: begin
        res = w_q | lit;
        updZ = 1'b1;
        wrW = 1'b1;
      end
      6'b1110??: begin
        res = w_q & lit;
        updZ = 1'b1;
        wrW = 1'b1;
      end
      default: begin
        res = w_q ^ lit;
        updZ = 1'b1;
        wrW = 1'b1;
      end
    endcase
    if (useD) begin
      wrF = dBit;
      wrW = ~dBit;
    end
  end

  // ----------------------------------------
  // next-state terms
  // ----------------------------------------
  wire wrPcl = wrF & (fa == `CPUC_A_PCL);
  wire redirect = jump | wrPcl;
  wire flush = redirect | skip;
  wire [PC_W-1:0] pcTarget = wrPcl ? {{(PC_W-8){1'b0}}, res} : target;
  wire [PC_W-1:0] pcOne = {{(PC_W-1){1'b0}}, 1'b1};
  wire [7:0] fsrNext = (wrF & (fa == `CPUC_A_FSR)) ? res : fsr_q;
  wire [11:0] nextInstr = flush ? `CPUC_NOP : progData;
  wire [4:0] nextAddr = (nextInstr[4:0] == `CPUC_A_INDF) ? fsrNext[4:0] : nextInstr[4:0];
  wire wrExt = wrF & faExt;
  reg [7:0] statusNext;
  always @* begin
    statusNext = status_q;
    // bits 4:3 are read-only
    if (wrF && (fa == `CPUC_A_STATUS)) begin
      statusNext = {res[7:5], status_q[4:3], res[2:0]};
    end
    // flag results take priority over a direct status write
    if (updC) begin
      statusNext[`CPUC_BIT_C] = cNew;
    end
    if (updDC) begin
      statusNext[`CPUC_BIT_DC] = dcNew;
    end
    if (updZ) begin
      statusNext[`CPUC_BIT_Z] = (res == 8'h00);
    end
  end

  // ----------------------------------------
  // sequential update
  // ----------------------------------------
  always @(posedge clock or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pc_q <= `CPUC_RESET_VEC;
      instr_q <= `CPUC_NOP;
      w_q <= `CPUC_W_RST;
      status_q <= `CPUC_STATUS_RST;
      fsr_q <= `CPUC_FSR_RST;
      dataRdAddr_q <= 5'h00;
      dataWrAddr_q <= 5'h00;
      dataWrData_q <= 8'h00;
      dataWe_q <= 1'b0;
      for (i = 0; i < STACK_DEPTH; i = i + 1) begin
        stk_q[i] <= {PC_W{1'b0}};
      end
    end else if (clockEn) begin
      dataWe_q <= step & wrExt;
      if (step) begin
        pc_q <= redirect ? pcTarget : pc_q + pcOne;
        instr_q <= nextInstr;
        status_q <= statusNext;
        fsr_q <= fsrNext;
        dataRdAddr_q <= nextAddr;
        if (wrW) begin
          w_q <= res;
        end
        if (wrExt) begin
          dataWrAddr_q <= fa;
          dataWrData_q <= res;
        end
        // overflow drops the oldest entry, underflow repeats the deepest
        if (push) begin
          stk_q[0] <= pc_q;
          for (i = 1; i < STACK_DEPTH; i = i + 1) begin
            stk_q[i] <= stk_q[i-1];
          end
        end else if (pop) begin
          for (i = 0; i < STACK_DEPTH - 1; i = i + 1) begin
            stk_q[i] <= stk_q[i+1];
          end
        end
      end
    end
  end

  // no reset on ram: contents undefined after power-up
  always @(posedge clock) begin
    if (step && wrF && faRam) begin
      ram[fa] <= res;
    end
  end

  assign progAddr = pc_q;
  assign dataRdAddr = dataRdAddr_q;
  assign dataWrAddr = dataWrAddr_q;
  assign dataWrData = dataWrData_q;
  assign dataWe = dataWe_q;

endmodule // cpuc_core

// file: testbench/cpu_core_alu_datapath_test.sv
`timescale 1ns/1ns
module cpu_core_alu_datapath_test;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic clockEn = 1'b1;
  wire [8:0] progAddr;
  wire [11:0] progData;
  wire [4:0] dataRdAddr;
  wire [7:0] dataRdData;
  wire [4:0] dataWrAddr;
  wire [7:0] dataWrData;
  wire dataWe;
  int miscompares = 0;
  int checked = 0;
  int cyc = 0;
  int lastT = 0;
  logic [31:0] seenQ[$];

  cpuc_core #(.STACK_DEPTH(4), .PC_W(9)) cpuc_core_i (
    .clock(clock), .resetn(resetn), .clockEn(clockEn), .progAddr(progAddr), .progData(progData),
    .dataRdAddr(dataRdAddr), .dataRdData(dataRdData), .dataWrAddr(dataWrAddr), .dataWrData(dataWrData),
    .dataWe(dataWe));
  cpuc_partner #(.PC_W(9)) cpuc_partner_i (
    .clock(clock), .progAddr(progAddr), .progData(progData), .dataRdAddr(dataRdAddr),
    .dataRdData(dataRdData), .dataWrAddr(dataWrAddr), .dataWrData(dataWrData), .dataWe(dataWe));

  initial begin
    forever #25 clock = ~clock;
  end
  // ----
  // write log: {gap in clocks, addr, data}; gap 0 means unchecked
  // ----
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (dataWe === 1'b1) begin
      seenQ.push_back({16'(cyc - lastT), 3'h0, dataWrAddr, dataWrData});
      lastT = cyc;
    end
    if (cyc > 2000) begin
      miscompares++;
      close_out();
    end
  end
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmpWrites(input logic [31:0] expQ[$]);
    logic [31:0] s;
    chk(32'(seenQ.size()), 32'(expQ.size()));
    foreach (expQ[i]) begin
      s = (i < seenQ.size()) ? seenQ[i] : 32'hffffffff;
      if (expQ[i][31:16] == 16'h0000) s[31:16] = 16'h0000;
      chk(s, expQ[i]);
    end
  endtask
  task automatic prog(input logic [11:0] w[$]);
    for (int i = 0; i < 512; i++) cpuc_partner_i.mem[i] = 12'h000;
    foreach (w[i]) cpuc_partner_i.mem[i] = w[i];
  endtask
  // reset held 3 clocks, then run n clocks
  task automatic go(input int n);
    @(negedge clock);
    resetn = 1'b0;
    repeat (3) @(negedge clock);
    seenQ.delete();
    lastT = cyc;
    resetn = 1'b1;
    repeat (n) @(negedge clock);
  endtask
  // ----
  // scenarios
  // ----
  task automatic scnAlu();
    prog('{12'hc3a, 12'h1c6, 12'h025, 12'h203, 12'h026, 12'hc05, 12'h081, 12'h021,
      12'h203, 12'h025, 12'h000, 12'h085, 12'h203, 12'h026, 12'ha0e});
    cpuc_partner_i.file[6] = 8'hc8;
    cpuc_partner_i.file[1] = 8'h03;
    go(90);
    cmpWrites('{32'h00000502, 32'h0008061b, 32'h000c01fe, 32'h00080518, 32'h0010061f});
  endtask
  task automatic scnFlow();
    prog('{12'hc11, 12'h026, 12'h026, 12'ha05, 12'h025, 12'h026, 12'h910, 12'h021, 12'ha08});
    for (int i = 0; i < 3; i++) begin
      cpuc_partner_i.mem[16 + 4 * i] = 12'h914 + 12'(4 * i);
      cpuc_partner_i.mem[17 + 4 * i] = 12'h025;
      cpuc_partner_i.mem[18 + 4 * i] = 12'h801 + 12'(i);
    end
    cpuc_partner_i.mem[28] = 12'h804;
    go(160);
    cmpWrites('{32'h00000611, 32'h00040611, 32'h000c0611, 32'h002c0504, 32'h000c0503, 32'h000c0502,
      32'h000c0101});
  endtask
  // disabled clocks must only stretch the gap
  task automatic scnFreeze();
    prog('{12'hc06, 12'h024, 12'hc77, 12'h020, 12'h028, 12'hc00, 12'h208, 12'h025,
      12'hc0c, 12'h022, 12'h021, 12'h000, 12'h021, 12'ha0d});
    go(0);
    @(negedge clock iff dataWe === 1'b1);
    @(negedge clock);
    clockEn = 1'b0;
    repeat (8) @(negedge clock);
    clockEn = 1'b1;
    repeat (80) @(negedge clock);
    cmpWrites('{32'h00000677, 32'h00180577, 32'h0010010c});
  endtask
  // ----
  // closing
  // ----
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    scnAlu();
    scnFlow();
    scnFreeze();
    close_out();
  end
endmodule // cpu_core_alu_datapath_test

// file: testbench/cpuc_core_properties.sv
`timescale 1ns/1ns
module cpuc_core_properties #(
  parameter PC_W = 9
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  input wire clockEn,
  // program side
  input wire [PC_W-1:0] progAddr,
  input wire [11:0] progData,
  // data side
  input wire [4:0] dataRdAddr,
  input wire [7:0] dataRdData,
  input wire [4:0] dataWrAddr,
  input wire [7:0] dataWrData,
  input wire dataWe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // ----
  // sequences
  // ----
  sequence sStep;
    clockEn ##1 $changed(progAddr);
  endsequence
  // only sound while no goto word sits in a flushed slot
  sequence sGotoFetched;
    clockEn && (progData[11:9] == 3'b101) ##1 clockEn && $changed(progAddr) ##1 clockEn [*3];
  endsequence
  // ----
  // properties
  // ----
  AST_WE_PULSE: assert property (dataWe |=> !dataWe [*3])
    else $error("write strobe too long or too close");
  AST_PA_STANDS: assert property (sStep |=> $stable(progAddr) [*3])
    else $error("fetch address moved inside a cycle");
  AST_FREEZE: assert property (!clockEn |=> $stable(progAddr) && $stable(dataRdAddr) && $stable(dataWrData))
    else $error("state moved while disabled");
  AST_GOTO_TARGET: assert property (sGotoFetched |=> progAddr == $past(progData[8:0], 5))
    else $error("jump target wrong or late");
  AST_RD_STANDS: assert property ($changed(dataRdAddr) |-> $changed(progAddr) ##1 $stable(dataRdAddr) [*3])
    else $error("read address off the step");
  AST_WE_EXTERNAL: assert property (dataWe |-> dataWrAddr == 5'h01 || dataWrAddr == 5'h05 || dataWrAddr == 5'h06)
    else $error("write to an internal address");
  AST_WE_AT_STEP: assert property ($rose(dataWe) |-> $changed(progAddr) && $past(clockEn))
    else $error("write not on a step edge");
  AST_WR_HOLD: assert property ($fell(dataWe) |-> $stable(dataWrAddr) && $stable(dataWrData))
    else $error("write data not held");
  AST_RESET_VECTOR: assert property ($rose(resetn) |-> progAddr == {PC_W{1'b1}} ##[3:8] progAddr == {PC_W{1'b0}})
    else $error("reset fetch order wrong");
endmodule // cpuc_core_properties

bind cpuc_core cpuc_core_properties #(.PC_W(PC_W)) cpuc_core_properties_i (
  .clock(clock), .resetn(resetn), .clockEn(clockEn), .progAddr(progAddr), .progData(progData),
  .dataRdAddr(dataRdAddr), .dataRdData(dataRdData), .dataWrAddr(dataWrAddr), .dataWrData(dataWrData),
  .dataWe(dataWe));

// file: testbench/cpuc_partner.sv
`timescale 1ns/1ns
module cpuc_partner #(
  parameter PC_W = 9
) (
  // clock
  input wire clock,
  // program side
  input wire [PC_W-1:0] progAddr,
  output wire [11:0] progData,
  // data side
  input wire [4:0] dataRdAddr,
  output wire [7:0] dataRdData,
  input wire [4:0] dataWrAddr,
  input wire [7:0] dataWrData,
  input wire dataWe
);
  reg [11:0] mem [0:(1<<PC_W)-1];
  reg [7:0] file [0:31];
  reg [7:0] lastRd_q = 8'h00;
  wire mapped = (dataRdAddr == 5'h01) || (dataRdAddr == 5'h05) || (dataRdAddr == 5'h06);
  // whole word every fetch, own bus
  assign progData = mem[progAddr];
  // unmapped reads toggle, so a stale byte never looks right
  assign dataRdData = mapped ? file[dataRdAddr] : ~lastRd_q;
  always @(posedge clock) begin
    lastRd_q <= dataRdData;
    if (dataWe) file[dataWrAddr] <= dataWrData;
  end
endmodule // cpuc_partner
